// ### src/cgsmb_map.vh
// Register offsets, field positions, reset values and codes of the clock generator control bank
`ifndef CGSMB_MAP_VH
`define CGSMB_MAP_VH

// ==================================================
// Register indices
`define CGSMB_IDX_OUTPUT_ENABLE 8'h00
`define CGSMB_IDX_SPREAD_SWING 8'h01
`define CGSMB_IDX_PAIR_EDGE 8'h02
`define CGSMB_IDX_REF_CONTROL 8'h03
`define CGSMB_IDX_RSVD_FOUR 8'h04
`define CGSMB_IDX_REV_MAKER 8'h05
`define CGSMB_IDX_TYPE_IDENT 8'h06
`define CGSMB_IDX_READ_LENGTH 8'h07

// ==================================================
// Reset values of writable fields and of the latched strap readback
`define CGSMB_RST_OUTPUT_ENABLE 8'hff
`define CGSMB_RST_SW_OVERRIDE 1'h0
`define CGSMB_RST_SW_SELECT 2'h0
`define CGSMB_RST_AMPLITUDE 2'h2
`define CGSMB_RST_PAIR_EDGE 8'hff
`define CGSMB_RST_REF_EDGE 2'h1
`define CGSMB_RST_WAKE_ON_LAN 1'h0
`define CGSMB_RST_REF_ENABLE 1'h1
`define CGSMB_RST_READ_LENGTH 5'h08
`define CGSMB_RST_STRAP 2'h0

// ==================================================
// Reset values of pin stages, outputs and the block reader
`define CGSMB_RST_STRAP_SYNC 2'h0
`define CGSMB_RST_GATE_PINS 8'hff
`define CGSMB_RST_POWER_GOOD 1'h0
`define CGSMB_RST_PAIR_RUN 8'h00
`define CGSMB_RST_REF_RUN 1'h0
`define CGSMB_RST_READ_IDX 8'h00
`define CGSMB_RST_READ_DATA 8'h00
`define CGSMB_RST_READ_FLAG 1'h0
`define CGSMB_RST_READ_REMAIN 5'h00

// ==================================================
// Reserved bit read values
`define CGSMB_RSVD_SPREAD_BIT2 1'h1
`define CGSMB_RSVD_REF_LOW 4'hf
`define CGSMB_RSVD_BYTE_FOUR 8'h00
`define CGSMB_RSVD_LENGTH_TOP 3'h0
`define CGSMB_UNMAPPED_BYTE 8'h00

// ==================================================
// Field positions
`define CGSMB_SS_RB_HI 7
`define CGSMB_SS_RB_LO 6
`define CGSMB_SS_OVR_BIT 5
`define CGSMB_SS_SEL_HI 4
`define CGSMB_SS_SEL_LO 3
`define CGSMB_AMP_HI 1
`define CGSMB_AMP_LO 0
`define CGSMB_REF_EDGE_HI 7
`define CGSMB_REF_EDGE_LO 6
`define CGSMB_REF_WOL_BIT 5
`define CGSMB_REF_OE_BIT 4
`define CGSMB_LEN_HI 4
`define CGSMB_LEN_LO 0

// ==================================================
// Spread codes
`define CGSMB_SS_OFF 2'h0
`define CGSMB_SS_DOWN_QUARTER 2'h1
`define CGSMB_SS_RESERVED 2'h2
`define CGSMB_SS_DOWN_HALF 2'h3

`endif

// ### src/cgsmb_strap_latch.v
// Tri-level spread strap synchroniser and power-good latch
`timescale 1ns/1ps
`include "cgsmb_map.vh"

module cgsmb_strap_latch (
    input wire mclk,
    input wire rst_n,
    input wire strapAboveLow,
    input wire strapAboveMid,
    input wire pgRise,
    output reg [1:0] strapCode_ff
);

// ==================================================
// Synchroniser for the two comparator levels
reg [1:0] strapMeta_ff;
reg [1:0] strapSync_ff;

// Only the second stage is read by the latch
always @(posedge mclk) begin
    if (!rst_n) begin
        strapMeta_ff <= `CGSMB_RST_STRAP_SYNC;
        strapSync_ff <= `CGSMB_RST_STRAP_SYNC;
    end else begin
        strapMeta_ff <= {strapAboveMid, strapAboveLow};
        strapSync_ff <= strapMeta_ff;
    end
end

// ==================================================
// Capture on power-good rising; low 00, mid 01, high 11
always @(posedge mclk) begin
    if (!rst_n) begin
        strapCode_ff <= `CGSMB_RST_STRAP;
    end else if (pgRise) begin
        strapCode_ff <= {strapSync_ff[1], strapSync_ff[0]};
    end
end

endmodule

// ### src/cgsmb_block_read.v
// Block-read sequencer: byte count first, then consecutive register bytes
`timescale 1ns/1ps
`include "cgsmb_map.vh"

module cgsmb_block_read (
    input wire mclk,
    input wire rst_n,
    input wire rdStart,
    input wire [7:0] rdStartIdx,
    input wire rdAck,
    input wire rdStop,
    input wire [4:0] byteCount,
    input wire [7:0] regByte,
    output reg [7:0] rdIdx_ff,
    output reg [7:0] rdData_ff,
    output reg rdValid_ff,
    output reg rdLast_ff
);

reg [4:0] remain_ff;

// ==================================================
// Each host ack moves to the next byte; stop or a final ack ends it
always @(posedge mclk) begin
    if (!rst_n) begin
        rdIdx_ff <= `CGSMB_RST_READ_IDX;
        rdData_ff <= `CGSMB_RST_READ_DATA;
        rdValid_ff <= `CGSMB_RST_READ_FLAG;
        rdLast_ff <= `CGSMB_RST_READ_FLAG;
        remain_ff <= `CGSMB_RST_READ_REMAIN;
    end else if (rdStart) begin
        rdData_ff <= {`CGSMB_RSVD_LENGTH_TOP, byteCount};
        rdIdx_ff <= rdStartIdx;
        remain_ff <= byteCount;
        rdValid_ff <= 1'h1;
        rdLast_ff <= (byteCount == 5'h00);
    end else if (rdStop) begin
        rdValid_ff <= 1'h0;
        rdLast_ff <= 1'h0;
    end else if (rdAck && rdValid_ff) begin
        if (remain_ff == 5'h00) begin
            // Ack on the last byte is a host error; close the read anyway
            rdValid_ff <= 1'h0;
            rdLast_ff <= 1'h0;
        end else begin
            rdData_ff <= regByte;
            rdIdx_ff <= rdIdx_ff + 8'h01;
            remain_ff <= remain_ff - 5'h01;
            rdLast_ff <= (remain_ff == 5'h01);
        end
    end
end

endmodule

// ### src/cgsmb_regs.v
// Control and identification register bank of an eight-output clock generator
// Contract
// - A cleared output-enable bit overrides the pair's enable pin and holds that pair low/low.
// - The two spread readback bits show the latched strap: 00 low, 01 mid, 11 high.
// - The override bit resets to 0; at 0 the strap sets spread, at 1 the software bits do.
// - Software spread code 00 is off, 01 is -0.25 percent, 11 is -0.5 percent, 10 is not written.
// - The amplitude field picks 0.6, 0.7, 0.8 or 0.9 V swing for codes 00 to 11 and resets to 10.
// - Edge-speed bit n picks slow (0) or fast (1) for pair n and resets to 1.
// - Reference edge field decodes slowest to faster, resets to 01; its enable bit resets to 1.
// - Wake-on-LAN at 1 keeps the reference running in power-down, at 0 stops it; resets to 0.
// - Offset five is read-only with a fixed revision nibble above a fixed maker nibble.
// - Offset six is read-only with a fixed two-bit type code above a six-bit identity code.
// - The five-bit count field sets block-read length, resets to 8, and its top three bits are reserved.
// - A block read returns the count first, then consecutive bytes from the start index.
// - The output-enable byte holds one enable per pair, each resetting to 1, 0 giving low/low.
`timescale 1ns/1ps
`include "cgsmb_map.vh"

module cgsmb_regs #(
    // Identification values below are arbitrary
    parameter [3:0] REVISION_CODE = 4'h3,
    parameter [3:0] MAKER_CODE = 4'ha,
    parameter [1:0] PART_TYPE_CODE = 2'h2,
    parameter [5:0] PART_IDENT_CODE = 6'h15
) (
    input wire mclk,
    input wire rst_n,
    input wire wrEn,
    input wire [7:0] wrIdx,
    input wire [7:0] wrData,
    input wire rdStart,
    input wire [7:0] rdStartIdx,
    input wire rdAck,
    input wire rdStop,
    output wire [7:0] rdData,
    output wire rdValid,
    output wire rdLast,
    input wire [7:0] pairGatePin_n,
    input wire powerGoodPin,
    input wire strapAboveLow,
    input wire strapAboveMid,
    output reg [7:0] pairOutputRun_ff,
    output reg [7:0] pairEdgeFast_ff,
    output reg [1:0] amplitudeSel_ff,
    output reg [1:0] spreadSel_ff,
    output reg [1:0] refEdgeSel_ff,
    output reg refOutputRun_ff
);

// ==================================================
// Writable fields
reg [7:0] pairOutputGate_ff;
reg spreadSoftwareOverride_ff;
reg [1:0] spreadSoftwareSelect_ff;
reg [1:0] amplitude_ff;
reg [7:0] pairEdgeSpeed_ff;
reg [1:0] refEdge_ff;
reg refWakeOnLan_ff;
reg refEnable_ff;
reg [4:0] readbackLength_ff;

// ==================================================
// Pin synchronisers and power-good edge
reg [7:0] gateMeta_ff;
reg [7:0] gateSync_ff;
reg pgMeta_ff;
reg pgSync_ff;
reg pgPrev_ff;
wire pgRise;
wire [1:0] spreadStrapReadback;
wire [7:0] rdIdx;
wire [7:0] regByte;

// ==================================================
// Spread source picked from strap or software
reg [1:0] spreadSource;

// ==================================================
// Read mux, shared by the block reader and kept as one function
function [7:0] readByte;
    input [7:0] idx;
    input [7:0] oeByte;
    input [1:0] strapRb;
    input ovr;
    input [1:0] swSel;
    input [1:0] amp;
    input [7:0] edgeByte;
    input [1:0] refEdge;
    input wol;
    input refEn;
    input [4:0] len;
    begin
        case (idx)
            `CGSMB_IDX_OUTPUT_ENABLE: begin
                readByte = oeByte;
            end
            `CGSMB_IDX_SPREAD_SWING: begin
                readByte = {strapRb, ovr, swSel, `CGSMB_RSVD_SPREAD_BIT2, amp};
            end
            `CGSMB_IDX_PAIR_EDGE: begin
                readByte = edgeByte;
            end
            `CGSMB_IDX_REF_CONTROL: begin
                readByte = {refEdge, wol, refEn, `CGSMB_RSVD_REF_LOW};
            end
            `CGSMB_IDX_RSVD_FOUR: begin
                readByte = `CGSMB_RSVD_BYTE_FOUR;
            end
            `CGSMB_IDX_REV_MAKER: begin
                readByte = {REVISION_CODE, MAKER_CODE};
            end
            `CGSMB_IDX_TYPE_IDENT: begin
                readByte = {PART_TYPE_CODE, PART_IDENT_CODE};
            end
            `CGSMB_IDX_READ_LENGTH: begin
                readByte = {`CGSMB_RSVD_LENGTH_TOP, len};
            end
            default: begin
                readByte = `CGSMB_UNMAPPED_BYTE;
            end
        endcase
    end
endfunction

// ==================================================
// Spread decode: reserved code 10 is treated as off so the PLL never sees it
function [1:0] spreadDecode;
    input [1:0] code;
    begin
        case (code)
            `CGSMB_SS_OFF: begin
                spreadDecode = `CGSMB_SS_OFF;
            end
            `CGSMB_SS_DOWN_QUARTER: begin
                spreadDecode = `CGSMB_SS_DOWN_QUARTER;
            end
            `CGSMB_SS_DOWN_HALF: begin
                spreadDecode = `CGSMB_SS_DOWN_HALF;
            end
            default: begin
                spreadDecode = `CGSMB_SS_OFF;
            end
        endcase
    end
endfunction

// ==================================================
// Pins from outside the clock domain pass two flops first
always @(posedge mclk) begin
    if (!rst_n) begin
        gateMeta_ff <= `CGSMB_RST_GATE_PINS;
        gateSync_ff <= `CGSMB_RST_GATE_PINS;
    end else begin
        gateMeta_ff <= pairGatePin_n;
        gateSync_ff <= gateMeta_ff;
    end
end

// ==================================================
// Power good gets the same two flops, plus one more to find its rise
always @(posedge mclk) begin
    if (!rst_n) begin
        pgMeta_ff <= `CGSMB_RST_POWER_GOOD;
        pgSync_ff <= `CGSMB_RST_POWER_GOOD;
        pgPrev_ff <= `CGSMB_RST_POWER_GOOD;
    end else begin
        pgMeta_ff <= powerGoodPin;
        pgSync_ff <= pgMeta_ff;
        pgPrev_ff <= pgSync_ff;
    end
end

assign pgRise = pgSync_ff & ~pgPrev_ff;

// ==================================================
// Strap latch on each power-good rise
cgsmb_strap_latch strapLatch (
    .mclk(mclk),
    .rst_n(rst_n),
    .strapAboveLow(strapAboveLow),
    .strapAboveMid(strapAboveMid),
    .pgRise(pgRise),
    .strapCode_ff(spreadStrapReadback)
);

// ==================================================
// Register writes; only writable bit positions are taken
always @(posedge mclk) begin
    if (!rst_n) begin
        pairOutputGate_ff <= `CGSMB_RST_OUTPUT_ENABLE;
        spreadSoftwareOverride_ff <= `CGSMB_RST_SW_OVERRIDE;
        spreadSoftwareSelect_ff <= `CGSMB_RST_SW_SELECT;
        amplitude_ff <= `CGSMB_RST_AMPLITUDE;
        pairEdgeSpeed_ff <= `CGSMB_RST_PAIR_EDGE;
        refEdge_ff <= `CGSMB_RST_REF_EDGE;
        refWakeOnLan_ff <= `CGSMB_RST_WAKE_ON_LAN;
        refEnable_ff <= `CGSMB_RST_REF_ENABLE;
        readbackLength_ff <= `CGSMB_RST_READ_LENGTH;
    end else if (wrEn) begin
        case (wrIdx)
            `CGSMB_IDX_OUTPUT_ENABLE: begin
                pairOutputGate_ff <= wrData;
            end
            `CGSMB_IDX_SPREAD_SWING: begin
                // Readback bits and bit 2 are dropped
                spreadSoftwareOverride_ff <= wrData[`CGSMB_SS_OVR_BIT];
                spreadSoftwareSelect_ff <= wrData[`CGSMB_SS_SEL_HI:`CGSMB_SS_SEL_LO];
                amplitude_ff <= wrData[`CGSMB_AMP_HI:`CGSMB_AMP_LO];
            end
            `CGSMB_IDX_PAIR_EDGE: begin
                pairEdgeSpeed_ff <= wrData;
            end
            `CGSMB_IDX_REF_CONTROL: begin
                refEdge_ff <= wrData[`CGSMB_REF_EDGE_HI:`CGSMB_REF_EDGE_LO];
                refWakeOnLan_ff <= wrData[`CGSMB_REF_WOL_BIT];
                refEnable_ff <= wrData[`CGSMB_REF_OE_BIT];
            end
            `CGSMB_IDX_READ_LENGTH: begin
                readbackLength_ff <= wrData[`CGSMB_LEN_HI:`CGSMB_LEN_LO];
            end
            default: begin
                // Read-only, reserved and unmapped bytes ignore writes
                pairOutputGate_ff <= pairOutputGate_ff;
            end
        endcase
    end
end

// ==================================================
// Spread source: software bits only count while the override is set
always @* begin
    if (spreadSoftwareOverride_ff) begin
        spreadSource = spreadSoftwareSelect_ff;
    end else begin
        spreadSource = spreadStrapReadback;
    end
end

// ==================================================
// Pair controls, registered so the analog side sees no glitch
always @(posedge mclk) begin
    if (!rst_n) begin
        pairOutputRun_ff <= `CGSMB_RST_PAIR_RUN;
        pairEdgeFast_ff <= `CGSMB_RST_PAIR_EDGE;
        amplitudeSel_ff <= `CGSMB_RST_AMPLITUDE;
    end else begin
        // A pair runs only with power good, its pin low and its enable bit set
        pairOutputRun_ff <= {8{pgSync_ff}} & ~gateSync_ff & pairOutputGate_ff;
        pairEdgeFast_ff <= pairEdgeSpeed_ff;
        amplitudeSel_ff <= amplitude_ff;
    end
end

// ==================================================
// Spread setting; the decode keeps the reserved code away from the PLL
always @(posedge mclk) begin
    if (!rst_n) begin
        spreadSel_ff <= `CGSMB_SS_OFF;
    end else begin
        spreadSel_ff <= spreadDecode(spreadSource);
    end
end

// ==================================================
// Reference controls; in power-down only wake-on-LAN keeps it alive
always @(posedge mclk) begin
    if (!rst_n) begin
        refEdgeSel_ff <= `CGSMB_RST_REF_EDGE;
        refOutputRun_ff <= `CGSMB_RST_REF_RUN;
    end else begin
        refEdgeSel_ff <= refEdge_ff;
        refOutputRun_ff <= refEnable_ff & (pgSync_ff | refWakeOnLan_ff);
    end
end

// ==================================================
// Block-read data path
assign regByte = readByte(rdIdx, pairOutputGate_ff, spreadStrapReadback, spreadSoftwareOverride_ff,
    spreadSoftwareSelect_ff, amplitude_ff, pairEdgeSpeed_ff, refEdge_ff, refWakeOnLan_ff,
    refEnable_ff, readbackLength_ff);

cgsmb_block_read blockRead (
    .mclk(mclk),
    .rst_n(rst_n),
    .rdStart(rdStart),
    .rdStartIdx(rdStartIdx),
    .rdAck(rdAck),
    .rdStop(rdStop),
    .byteCount(readbackLength_ff),
    .regByte(regByte),
    .rdIdx_ff(rdIdx),
    .rdData_ff(rdData),
    .rdValid_ff(rdValid),
    .rdLast_ff(rdLast)
);

endmodule

// ### dv/cgsmb_regs_assertions.sv
// Port-level checker for the clock generator control bank
`timescale 1ns/1ps
module cgsmb_regs_chk (
    input wire mclk,
    input wire rst_n,
    input wire wrEn,
    input wire [7:0] wrIdx,
    input wire [7:0] wrData,
    input wire rdStart,
    input wire [7:0] rdStartIdx,
    input wire rdAck,
    input wire rdStop,
    input wire [7:0] rdData,
    input wire rdValid,
    input wire rdLast,
    input wire [7:0] pairGatePin_n,
    input wire powerGoodPin,
    input wire strapAboveLow,
    input wire strapAboveMid,
    input wire [7:0] pairOutputRun_ff,
    input wire [7:0] pairEdgeFast_ff,
    input wire [1:0] amplitudeSel_ff,
    input wire [1:0] spreadSel_ff,
    input wire [1:0] refEdgeSel_ff,
    input wire refOutputRun_ff
);
    // ==========
    // Enable shadows, updated on the same edge as the bank itself
    logic [7:0] oeShad_ff;
    logic wolShad_ff;
    always @(posedge mclk) begin
        if (!rst_n) begin
            oeShad_ff <= 8'hff;
            wolShad_ff <= 1'b0;
        end else if (wrEn && wrIdx == 8'h00) begin
            oeShad_ff <= wrData;
        end else if (wrEn && wrIdx == 8'h03) begin
            wolShad_ff <= wrData[5];
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RST_VALUES: assert property (disable iff (1'b0) !rst_n |=>
        pairEdgeFast_ff == 8'hff && amplitudeSel_ff == 2'h2 && refEdgeSel_ff == 2'h1) else $error("reset values");
    AST_EDGE_WRITE: assert property (wrEn && wrIdx == 8'h02
        |-> ##2 pairEdgeFast_ff == $past(wrData, 2)) else $error("edge byte not applied");
    AST_AMP_WRITE: assert property (wrEn && wrIdx == 8'h01
        |-> ##2 {6'h0, amplitudeSel_ff} == ($past(wrData, 2) & 8'h03)) else $error("amplitude not applied");
    AST_SW_SPREAD: assert property (wrEn && wrIdx == 8'h01 && wrData[5] && wrData[4:3] != 2'h2
        |-> ##2 {3'h0, spreadSel_ff, 3'h0} == ($past(wrData, 2) & 8'h18)) else $error("spread not applied");
    AST_NO_RSVD_SPREAD: assert property (spreadSel_ff != 2'h2) else $error("reserved spread code");
    AST_REF_EDGE: assert property (wrEn && wrIdx == 8'h03
        |-> ##2 {refEdgeSel_ff, 6'h0} == ($past(wrData, 2) & 8'hc0)) else $error("ref edge not applied");
    AST_OE_OVERRIDE: assert property ((pairOutputRun_ff & ~$past(oeShad_ff)) == 8'h00)
        else $error("disabled pair runs");
    AST_WOL_STOP: assert property ((!powerGoodPin && !wolShad_ff) [*4] |-> !refOutputRun_ff)
        else $error("ref runs in power-down");
    AST_RD_START: assert property (rdStart |=> rdValid && rdData[7:5] == 3'h0)
        else $error("count byte missing");
    AST_RD_STOP: assert property (rdStop && !rdStart |=> !rdValid && !rdLast)
        else $error("read not closed");
endmodule
bind cgsmb_regs cgsmb_regs_chk chk_u (.*);

// ### dv/cgsmb_host_model.sv
// Behavioural SMBus host driving the byte port of the bank
`timescale 1ns/1ps
module cgsmb_host_model (
    input wire mclk,
    input wire [7:0] rdData,
    input wire rdValid,
    input wire rdLast,
    output logic wrEn = 1'b0,
    output logic [7:0] wrIdx = 8'h00,
    output logic [7:0] wrData = 8'h00,
    output logic rdStart = 1'b0,
    output logic [7:0] rdStartIdx = 8'h00,
    output logic rdAck = 1'b0,
    output logic rdStop = 1'b0
);
    logic [7:0] got [0:39];
    int gotN;
    logic lastSeen;
    // Idle data is inverted so a stale value is never mistaken for a request
    task automatic writeByte(input logic [7:0] i, input logic [7:0] d);
        @(posedge mclk);
        wrEn <= 1'b1;
        wrIdx <= i;
        wrData <= d;
        @(posedge mclk);
        wrEn <= 1'b0;
        wrIdx <= ~i;
        wrData <= ~d;
    endtask
    // Acks every byte but the last, which ends with stop; gap slows the host
    task automatic readBlock(input logic [7:0] i, input int gap);
        gotN = 0;
        @(posedge mclk);
        rdStart <= 1'b1;
        rdStartIdx <= i;
        @(posedge mclk);
        rdStart <= 1'b0;
        #1;
        while (rdValid === 1'b1 && gotN < 40) begin
            got[gotN] = rdData;
            lastSeen = rdLast;
            gotN++;
            repeat (gap) @(posedge mclk);
            @(posedge mclk);
            if (lastSeen === 1'b1) rdStop <= 1'b1;
            else rdAck <= 1'b1;
            @(posedge mclk);
            rdStop <= 1'b0;
            rdAck <= 1'b0;
            #1;
        end
    endtask
endmodule

// ### dv/tb_top.sv
// Randomised self-checking bench for the control register bank
`timescale 1ns/1ps
module tb_top;
    localparam logic [3:0] REV = 4'h6; // Arbitrary
    localparam logic [3:0] MKR = 4'h9; // Arbitrary
    localparam logic [1:0] TYP = 2'h1; // Arbitrary
    localparam logic [5:0] IDN = 6'h2c; // Arbitrary
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic pg = 1'b0;
    logic sLow = 1'b0;
    logic sMid = 1'b0;
    logic [7:0] pinN = 8'h00;
    logic wrEn, rdStart, rdAck, rdStop, rdValid, rdLast, refRun;
    logic [7:0] wrIdx, wrData, rdStartIdx, rdData, pairRun, pairFast;
    logic [1:0] amp, spr, refEdge;
    logic [7:0] img [0:7];
    int numErrors = 0;
    int checksDone = 0;
    int len;
    always #12.5 mclk = ~mclk;
    cgsmb_regs #(.REVISION_CODE(REV), .MAKER_CODE(MKR), .PART_TYPE_CODE(TYP), .PART_IDENT_CODE(IDN)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .rdStart(rdStart),
        .rdStartIdx(rdStartIdx), .rdAck(rdAck), .rdStop(rdStop), .rdData(rdData), .rdValid(rdValid),
        .rdLast(rdLast), .pairGatePin_n(pinN), .powerGoodPin(pg), .strapAboveLow(sLow),
        .strapAboveMid(sMid), .pairOutputRun_ff(pairRun), .pairEdgeFast_ff(pairFast),
        .amplitudeSel_ff(amp), .spreadSel_ff(spr), .refEdgeSel_ff(refEdge), .refOutputRun_ff(refRun));
    cgsmb_host_model host_u (.mclk(mclk), .rdData(rdData), .rdValid(rdValid), .rdLast(rdLast),
        .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .rdStart(rdStart), .rdStartIdx(rdStartIdx),
        .rdAck(rdAck), .rdStop(rdStop));
    // ==========
    // Comparison, expectation and stimulus helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checksDone++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] expByte(input logic [7:0] i);
        return (i < 8'h08) ? img[i[2:0]] : 8'h00;
    endfunction
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] m;
        m = (i == 8'h01) ? 8'h3b : (i == 8'h03) ? 8'hf0 : (i == 8'h07) ? 8'h1f : (i > 8'h03) ? 8'h00 : 8'hff;
        host_u.writeByte(i, d);
        if (i < 8'h08) img[i[2:0]] = (img[i[2:0]] & ~m) | (d & m);
    endtask
    task automatic pins(input logic [7:0] n, input logic p);
        @(posedge mclk);
        pinN <= n;
        pg <= p;
        if (p && !pg) img[1][7:6] = {sMid, sLow};
    endtask
    task automatic rdChk(input logic [7:0] s, input int gap);
        len = img[7][4:0];
        host_u.readBlock(s, gap);
        chk(8'(host_u.gotN), 8'(len + 1));
        chk(host_u.got[0], 8'(len));
        for (int k = 0; k < len; k++) chk(host_u.got[k + 1], expByte(s + 8'(k)));
    endtask
    // Pin paths need three edges and the strap four, so six is safe
    task automatic chkOut();
        repeat (6) @(posedge mclk);
        #1;
        chk(pairRun, img[0] & ~pinN & {8{pg}});
        chk(pairFast, img[2]);
        chk({6'h0, amp}, {6'h0, img[1][1:0]});
        chk({6'h0, spr}, {6'h0, img[1][5] ? img[1][4:3] : img[1][7:6]});
        chk({6'h0, refEdge}, {6'h0, img[3][7:6]});
        chk({7'h0, refRun}, {7'h0, img[3][4] & (pg | img[3][5])});
    endtask
    task automatic completeRun();
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        void'($urandom(33801));
        img = '{8'hff, 8'h06, 8'hff, 8'h5f, 8'h00, {REV, MKR}, {TYP, IDN}, 8'h08};
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        chkOut();
        rdChk(8'h00, 0);
        $display("test reset done");
        for (int j = 0; j < 3; j++) begin
            pins(8'h00, 1'b0);
            sLow <= (j > 0);
            sMid <= (j == 2);
            repeat (4) @(posedge mclk);
            pins(8'h00, 1'b1);
            wr(8'h01, 8'h02);
            chkOut();
            rdChk(8'h01, j);
            for (int c = 0; c < 4; c++) begin
                if (c != 2) wr(8'h01, 8'h20 | 8'(c << 3) | 8'(c));
                chkOut();
            end
        end
        $display("test strap done");
        wr(8'h07, 8'h05);
        rdChk(8'hfe, 1);
        wr(8'h07, 8'he0);
        rdChk(8'h03, 0);
        $display("test corner done");
        for (int t = 0; t < 40; t++) begin
            logic [7:0] i;
            logic [7:0] d;
            i = 8'($urandom % 10);
            d = 8'($urandom);
            if (i == 8'h01 && d[4:3] == 2'h2) d[4] = 1'b0;
            wr(i, d);
            pins(8'($urandom), ($urandom % 4) != 0);
            chkOut();
            if (t % 5 == 4) rdChk(8'($urandom % 12), $urandom % 4);
        end
        $display("test random done");
        completeRun();
    end
    // Generous limit, about twenty times the expected run
    initial begin
        #500000;
        numErrors++;
        completeRun();
    end
endmodule
